// ==== arc_regs.sv ====
// Register bank of ADC results, thresholds and result watch channels.
// Assumes a plain register port with one-cycle strobes and a sequencer
// that writes results as one-cycle store strobes.
//
// Operation
// - Normal result in 15:6, flags in 1:0, rest zero
// - Overwrite flag set on unread replacement
// - Reading clears the overwrite flag
// - Stored flag set on each store
// - Reading the result clears stored flag
// - Priority result in 15:6, flags in 1:0, rest zero
// - Priority flags behave like normal flags
// - Threshold 0 read/write in 15:6
// - Threshold 1 read/write in 15:6
// - Priority result and thresholds reset zero
// - Select code picks slot 0-7 or priority
// - Direction picks below or above threshold
// - Enabled channel compares on each store into its selected slot
`timescale 1ns/1ps
`default_nettype none
module arc_regs (
  input wire logic        clk_sys,      // System clock, 125 MHz
  input wire logic        rst_b,        // Async reset, active low
  input wire logic [7:0]  reg_addr,     // Register byte address
  input wire logic [31:0] reg_wdata,    // Write data
  input wire logic        reg_wr,       // Write strobe
  input wire logic        reg_rd,       // Read strobe
  output logic     [31:0] reg_rdata,    // Read data, cycle after strobe
  input wire logic        conv_store,   // Normal result store strobe
  input wire logic [3:0]  conv_index,   // Normal slot 0 to 11
  input wire logic [9:0]  conv_result,  // Normal result value
  input wire logic        prio_store,   // Priority result store strobe
  input wire logic [9:0]  prio_result,  // Priority result value
  output logic            irq           // Level interrupt
);
  localparam int unsigned NS = arc_pkg::ARC_NUM_SLOTS;
  localparam int unsigned NN = arc_pkg::ARC_NUM_NORMAL;

  // Address match for a register offset
  function automatic logic reg_hit(input logic [7:0] addr,
                                   input logic [7:0] ofs);
    reg_hit = (addr == ofs);
  endfunction : reg_hit

  // Pack a result word: value and flags, other bits zero
  function automatic logic [31:0] pack_result(input logic [9:0] val,
                                              input logic       ovr,
                                              input logic       stored);
    logic [31:0] w;
    w = arc_pkg::WORD_ZERO;
    w[arc_pkg::RES_MSB:arc_pkg::RES_LSB] = val;
    w[arc_pkg::OVR_BIT]    = ovr;
    w[arc_pkg::STORED_BIT] = stored;
    pack_result = w;
  endfunction : pack_result

  // Pack a threshold word: field in 15:6, other bits zero
  function automatic logic [31:0] pack_thresh(input logic [9:0] val);
    logic [31:0] w;
    w = arc_pkg::WORD_ZERO;
    w[arc_pkg::RES_MSB:arc_pkg::RES_LSB] = val;
    pack_thresh = w;
  endfunction : pack_thresh

  // Slot links and gathered slot state
  arc_slot_if slot_if [NS] ();
  logic [9:0]    slot_val [NS];  // Held results
  logic [NS-1:0] slot_ovr;       // Overwrite flags
  logic [NS-1:0] slot_stored;    // Stored flags
  logic [NS-1:0] slot_ovr_evt;   // Overwrite events
  logic [NS-1:0] slot_store;     // Store strobes
  logic [NS-1:0] slot_rd;        // Clearing reads

  // Software state
  logic [9:0]  thr0_q, thr0_d;      // Threshold value 0
  logic [9:0]  thr1_q, thr1_d;      // Threshold value 1
  logic [5:0]  wctl0_q, wctl0_d;    // Watch control 0
  logic [5:0]  wctl1_q, wctl1_d;    // Watch control 1
  logic [3:0]  irq_st_q, irq_st_d;  // Sticky interrupt status
  logic [3:0]  irq_mk_q, irq_mk_d;  // Interrupt mask
  logic [31:0] rdata_q, rdata_d;    // Read data register
  logic [3:0]  irq_set;             // Events this cycle
  logic        hit0, hit1;          // Watch events

  // One result slot per register, slot 12 is the priority result
  for (genvar g = 0; g < NS; g++) begin : g_slot
    if (g < NN) begin : g_norm
      // Normal slots take the sequencer store by index
      assign slot_store[g] = conv_store && conv_index == 4'(g);
      assign slot_if[g].store_val = conv_result;
    end else begin : g_prio
      // Priority slot has its own store strobe
      assign slot_store[g] = prio_store;
      assign slot_if[g].store_val = prio_result;
    end
    // Reading the word clears both flags of the slot
    assign slot_rd[g] = reg_rd &&
      reg_hit(reg_addr, arc_pkg::OFS_RESULT_0 + 8'(4 * g));
    assign slot_if[g].store    = slot_store[g];
    assign slot_if[g].read_clr = slot_rd[g];
    assign slot_val[g]         = slot_if[g].value;
    assign slot_ovr[g]         = slot_if[g].ovr;
    assign slot_stored[g]      = slot_if[g].stored;
    assign slot_ovr_evt[g]     = slot_if[g].ovr_evt;

    arc_result_slot u_slot (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .slot    (slot_if[g])
    );
  end

  // Watch channel 0
  arc_watch u_watch0 (
    .clk_sys    (clk_sys),
    .rst_b      (rst_b),
    .enable     (wctl0_q[arc_pkg::WCTL_EN_BIT]),
    .target_sel (wctl0_q[arc_pkg::WCTL_SEL_MSB:arc_pkg::WCTL_SEL_LSB]),
    .direction  (wctl0_q[arc_pkg::WCTL_DIR_BIT]),
    .threshold  (thr0_q),
    .slot_store (slot_store),
    .norm_val   (conv_result),
    .prio_val   (prio_result),
    .hit        (hit0)
  );

  // Watch channel 1
  arc_watch u_watch1 (
    .clk_sys    (clk_sys),
    .rst_b      (rst_b),
    .enable     (wctl1_q[arc_pkg::WCTL_EN_BIT]),
    .target_sel (wctl1_q[arc_pkg::WCTL_SEL_MSB:arc_pkg::WCTL_SEL_LSB]),
    .direction  (wctl1_q[arc_pkg::WCTL_DIR_BIT]),
    .threshold  (thr1_q),
    .slot_store (slot_store),
    .norm_val   (conv_result),
    .prio_val   (prio_result),
    .hit        (hit1)
  );

  // Register writes; thresholds accept any write, software keeps
  // the channel disabled while changing them
  always_comb begin
    thr0_d  = thr0_q;
    thr1_d  = thr1_q;
    wctl0_d = wctl0_q;
    wctl1_d = wctl1_q;
    irq_mk_d = irq_mk_q;
    if (reg_wr) begin
      if (reg_hit(reg_addr, arc_pkg::OFS_THRESH_0)) begin
        thr0_d = reg_wdata[arc_pkg::RES_MSB:arc_pkg::RES_LSB];
      end
      if (reg_hit(reg_addr, arc_pkg::OFS_THRESH_1)) begin
        thr1_d = reg_wdata[arc_pkg::RES_MSB:arc_pkg::RES_LSB];
      end
      if (reg_hit(reg_addr, arc_pkg::OFS_WATCH_CTL_0)) begin
        wctl0_d = reg_wdata[5:0];
      end
      if (reg_hit(reg_addr, arc_pkg::OFS_WATCH_CTL_1)) begin
        wctl1_d = reg_wdata[5:0];
      end
      if (reg_hit(reg_addr, arc_pkg::OFS_IRQ_MASK)) begin
        irq_mk_d = reg_wdata[3:0];
      end
    end
  end

  // Sticky status: events set, write one clears, set wins
  always_comb begin
    irq_set = arc_pkg::IRQ_RST;
    irq_set[arc_pkg::IRQ_WATCH_0]  = hit0;
    irq_set[arc_pkg::IRQ_WATCH_1]  = hit1;
    irq_set[arc_pkg::IRQ_OVR_NORM] = |slot_ovr_evt[NN-1:0];
    irq_set[arc_pkg::IRQ_OVR_PRIO] = slot_ovr_evt[NS-1];
    irq_st_d = irq_st_q;
    if (reg_wr && reg_hit(reg_addr, arc_pkg::OFS_IRQ_STATUS)) begin
      irq_st_d = irq_st_q & ~reg_wdata[3:0];
    end
    irq_st_d = irq_st_d | irq_set;
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata_d = arc_pkg::WORD_ZERO;
    if (reg_rd) begin
      for (int i = 0; i < NS; i++) begin
        if (slot_rd[i]) begin
          rdata_d = pack_result(slot_val[i], slot_ovr[i],
                                slot_stored[i]);
        end
      end
      if (reg_hit(reg_addr, arc_pkg::OFS_THRESH_0)) begin
        rdata_d = pack_thresh(thr0_q);
      end
      if (reg_hit(reg_addr, arc_pkg::OFS_THRESH_1)) begin
        rdata_d = pack_thresh(thr1_q);
      end
      if (reg_hit(reg_addr, arc_pkg::OFS_WATCH_CTL_0)) begin
        rdata_d = {26'h0, wctl0_q};
      end
      if (reg_hit(reg_addr, arc_pkg::OFS_WATCH_CTL_1)) begin
        rdata_d = {26'h0, wctl1_q};
      end
      if (reg_hit(reg_addr, arc_pkg::OFS_IRQ_STATUS)) begin
        rdata_d = {28'h0, irq_st_q};
      end
      if (reg_hit(reg_addr, arc_pkg::OFS_IRQ_MASK)) begin
        rdata_d = {28'h0, irq_mk_q};
      end
    end
  end

  // All software registers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      thr0_q   <= arc_pkg::THRESH_RST;
      thr1_q   <= arc_pkg::THRESH_RST;
      wctl0_q  <= arc_pkg::WCTL_RST;
      wctl1_q  <= arc_pkg::WCTL_RST;
      irq_st_q <= arc_pkg::IRQ_RST;
      irq_mk_q <= arc_pkg::IRQ_RST;
      rdata_q  <= arc_pkg::WORD_ZERO;
    end else begin
      thr0_q   <= thr0_d;
      thr1_q   <= thr1_d;
      wctl0_q  <= wctl0_d;
      wctl1_q  <= wctl1_d;
      irq_st_q <= irq_st_d;
      irq_mk_q <= irq_mk_d;
      rdata_q  <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign irq       = |(irq_st_q & irq_mk_q);

  // Checks on the bank
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  // Read strobe on threshold 0
  sequence s_thr0_read;
    reg_rd && reg_hit(reg_addr, arc_pkg::OFS_THRESH_0);
  endsequence

  // Read strobe on threshold 1
  sequence s_thr1_read;
    reg_rd && reg_hit(reg_addr, arc_pkg::OFS_THRESH_1);
  endsequence

  // Store of an unread normal result
  sequence s_norm_overwrite;
    conv_store && conv_index < 4'hc && !reg_rd &&
    slot_stored[conv_index];
  endsequence

  // Priority store above threshold 1, channel 1 aimed at it
  sequence s_prio_above_1;
    wctl1_q[arc_pkg::WCTL_EN_BIT] && wctl1_q[arc_pkg::WCTL_SEL_MSB] &&
    wctl1_q[arc_pkg::WCTL_DIR_BIT] && prio_store &&
    prio_result > thr1_q;
  endsequence

  // Threshold 0 reads back in 15:6
  a_thr0_readback: assert property (
    s_thr0_read |=> reg_rdata == pack_thresh($past(thr0_q)))
    else $error("threshold 0 read data wrong");

  // Threshold 1 reads back in 15:6
  a_thr1_readback: assert property (
    s_thr1_read |=> reg_rdata == pack_thresh($past(thr1_q)))
    else $error("threshold 1 read data wrong");

  // Threshold writes land in the next cycle
  a_thr0_write: assert property (
    reg_wr && reg_hit(reg_addr, arc_pkg::OFS_THRESH_0) |=>
      thr0_q == $past(reg_wdata[arc_pkg::RES_MSB:arc_pkg::RES_LSB]))
    else $error("threshold 0 write lost");
  a_thr1_write: assert property (
    reg_wr && reg_hit(reg_addr, arc_pkg::OFS_THRESH_1) |=>
      thr1_q == $past(reg_wdata[arc_pkg::RES_MSB:arc_pkg::RES_LSB]))
    else $error("threshold 1 write lost");

  // Result words keep their spare bits at zero
  a_result_zero_bits: assert property (
    $past(|slot_rd) |-> reg_rdata[31:16] == 16'h0000 &&
                        reg_rdata[5:2] == 4'h0)
    else $error("reserved result bits not zero");

  // Read data falls back to zero between reads
  a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == arc_pkg::WORD_ZERO)
    else $error("read data not zero outside a read");

  // Unread normal result replaced: status bit next cycle
  a_norm_overwrite: assert property (
    s_norm_overwrite |=> irq_st_q[arc_pkg::IRQ_OVR_NORM])
    else $error("overwrite not reported in status");

  // Priority store lands with its stored flag
  a_prio_store_flag: assert property (
    prio_store |=> slot_stored[12] && slot_val[12] == $past(prio_result))
    else $error("priority store not held");

  // Read without store leaves both flags of the slot low
  a_read_clears_all: assert property (
    (|(slot_rd & ~slot_store)) |=>
      ((slot_stored | slot_ovr) & $past(slot_rd & ~slot_store)) == '0)
    else $error("read left a flag set");

  // Every store sets its stored flag, even beside a read
  a_store_beats_read: assert property (
    (|slot_store) |=> (slot_stored & $past(slot_store)) == $past(slot_store))
    else $error("store lost against a read");

  // Top bit of the select code watches the priority slot
  a_prio_select: assert property (
    s_prio_above_1 |=> hit1)
    else $error("channel 1 missed a priority store");

  // Thresholds and priority slot leave reset at zero
  a_reset_zero: assert property (
    !$past(rst_b) |-> thr0_q == arc_pkg::THRESH_RST &&
      thr1_q == arc_pkg::THRESH_RST &&
      slot_val[NS-1] == arc_pkg::RESULT_RST && !slot_stored[NS-1])
    else $error("register not zero after reset");

  // Unmasked event raises the interrupt next cycle
  a_irq_raise: assert property (
    (|(irq_set & irq_mk_q)) && !reg_wr |=> irq)
    else $error("unmasked event gave no interrupt");

  // Write of ones clears status bits with no event pending
  a_status_clear: assert property (
    reg_wr && reg_hit(reg_addr, arc_pkg::OFS_IRQ_STATUS) &&
    irq_set == arc_pkg::IRQ_RST |=>
      (irq_st_q & $past(reg_wdata[3:0])) == arc_pkg::IRQ_RST)
    else $error("status bit not cleared");
endmodule : arc_regs
`default_nettype wire

// ==== arc_pkg.sv ====
// Constants for the ADC result and compare register bank.
// Assumes a 32-bit register port with byte addresses on aligned words.
`default_nettype none
package arc_pkg;
  // Sizes
  localparam int unsigned ARC_NUM_NORMAL = 12;  // Normal result slots
  localparam int unsigned ARC_NUM_SLOTS  = 13;  // Normal plus priority
  localparam int unsigned ARC_RES_W      = 10;  // Result width
  localparam int unsigned ARC_ADDR_W     = 8;   // Register address width
  localparam int unsigned ARC_IRQ_W      = 4;   // Interrupt status width
  localparam int unsigned ARC_WCTL_W     = 6;   // Watch control width

  // Register byte offsets
  localparam logic [7:0] OFS_RESULT_0    = 8'h00;  // Slot n at 4*n
  localparam logic [7:0] OFS_PRIORITY    = 8'h30;  // Slot 12
  localparam logic [7:0] OFS_THRESH_0    = 8'h34;
  localparam logic [7:0] OFS_THRESH_1    = 8'h38;
  localparam logic [7:0] OFS_WATCH_CTL_0 = 8'h3c;
  localparam logic [7:0] OFS_WATCH_CTL_1 = 8'h40;
  localparam logic [7:0] OFS_IRQ_STATUS  = 8'h44;
  localparam logic [7:0] OFS_IRQ_MASK    = 8'h48;

  // Field positions
  localparam int unsigned RES_LSB      = 6;  // Result and threshold field
  localparam int unsigned RES_MSB      = 15;
  localparam int unsigned OVR_BIT      = 1;  // Overwrite flag
  localparam int unsigned STORED_BIT   = 0;  // Stored flag
  localparam int unsigned WCTL_EN_BIT  = 0;  // Watch enable
  localparam int unsigned WCTL_SEL_LSB = 1;  // Watch target select [4:1]
  localparam int unsigned WCTL_SEL_MSB = 4;
  localparam int unsigned WCTL_DIR_BIT = 5;  // Watch direction
  localparam int unsigned IRQ_WATCH_0  = 0;  // Interrupt status bits
  localparam int unsigned IRQ_WATCH_1  = 1;
  localparam int unsigned IRQ_OVR_NORM = 2;
  localparam int unsigned IRQ_OVR_PRIO = 3;

  // Reset values
  localparam logic [9:0]  RESULT_RST = 10'h000;
  localparam logic [9:0]  THRESH_RST = 10'h000;
  localparam logic [5:0]  WCTL_RST   = 6'h00;
  localparam logic [3:0]  IRQ_RST    = 4'h0;
  localparam logic [31:0] WORD_ZERO  = 32'h0000_0000;
endpackage : arc_pkg
`default_nettype wire

// ==== arc_slot_if.sv ====
// Link between the bank and one result slot.
// Assumes the bank drives store and clear, the slot answers with its state.
`timescale 1ns/1ps
`default_nettype none
interface arc_slot_if;
  logic       store;      // Sequencer writes a new result
  logic [9:0] store_val;  // Result being written
  logic       read_clr;   // Software reads this slot
  logic [9:0] value;      // Held result
  logic       ovr;        // Overwrite flag
  logic       stored;     // Stored flag
  logic       ovr_evt;    // Overwrite flag set this cycle
  modport owner (input store, store_val, read_clr,
                 output value, ovr, stored, ovr_evt);
  modport user  (output store, store_val, read_clr,
                 input value, ovr, stored, ovr_evt);
endinterface : arc_slot_if
`default_nettype wire

// ==== arc_result_slot.sv ====
// One conversion result with its stored and overwrite flags.
// Assumes store and read_clr are one-cycle strobes from the bank.
`timescale 1ns/1ps
`default_nettype none
module arc_result_slot (
  input wire logic   clk_sys,  // System clock
  input wire logic   rst_b,    // Async reset, active low
  arc_slot_if.owner  slot      // Store and read side
);
  logic [9:0] value_q, value_d;    // Held result
  logic       ovr_q, ovr_d;        // Overwrite flag
  logic       stored_q, stored_d;  // Stored flag
  logic       ovr_set;             // Unread result replaced

  // Next values: store sets, read clears, set wins
  always_comb begin
    ovr_set  = slot.store && stored_q && !slot.read_clr;
    value_d  = slot.store ? slot.store_val : value_q;
    stored_d = stored_q;
    if (slot.store) begin
      stored_d = 1'b1;
    end else if (slot.read_clr) begin
      stored_d = 1'b0;
    end
    ovr_d = ovr_q;
    if (ovr_set) begin
      ovr_d = 1'b1;
    end else if (slot.read_clr) begin
      ovr_d = 1'b0;
    end
  end

  // State registers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      value_q  <= arc_pkg::RESULT_RST;
      ovr_q    <= 1'b0;
      stored_q <= 1'b0;
    end else begin
      value_q  <= value_d;
      ovr_q    <= ovr_d;
      stored_q <= stored_d;
    end
  end

  assign slot.value   = value_q;
  assign slot.ovr     = ovr_q;
  assign slot.stored  = stored_q;
  assign slot.ovr_evt = ovr_set;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_store_sets_flag: assert property (
    slot.store |=> stored_q && value_q == $past(slot.store_val))
    else $error("store did not set stored flag and value");
  a_overwrite_sets: assert property (
    slot.store && stored_q && !slot.read_clr |=> ovr_q)
    else $error("overwrite of unread result not flagged");
  a_read_clears: assert property (
    slot.read_clr && !slot.store |=> !ovr_q && !stored_q)
    else $error("read did not clear flags");
endmodule : arc_result_slot
`default_nettype wire

// ==== arc_watch.sv ====
// One result watch channel comparing stored results to a threshold.
// Assumes per-slot store strobes and the values being stored.
`timescale 1ns/1ps
`default_nettype none
module arc_watch (
  input wire logic        clk_sys,     // System clock
  input wire logic        rst_b,       // Async reset, active low
  input wire logic        enable,      // Channel enable
  input wire logic [3:0]  target_sel,  // Watched slot code
  input wire logic        direction,   // 0 below, 1 above
  input wire logic [9:0]  threshold,   // Compare value
  input wire logic [12:0] slot_store,  // Store strobe per slot
  input wire logic [9:0]  norm_val,    // Normal result being stored
  input wire logic [9:0]  prio_val,    // Priority result being stored
  output logic            hit          // One-cycle watch event
);
  logic       hit_q, hit_d;  // Registered event
  logic       watched;       // Store into watched slot
  logic [9:0] val;           // Value stored there

  // Target decode and compare on each store
  always_comb begin
    if (target_sel[3]) begin
      watched = slot_store[12];
      val     = prio_val;
    end else begin
      watched = slot_store[target_sel[2:0]];
      val     = norm_val;
    end
    hit_d = 1'b0;
    if (enable && watched) begin
      hit_d = direction ? (val > threshold)
                        : (val < threshold);
    end
  end

  // Event register
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hit_q <= 1'b0;
    end else begin
      hit_q <= hit_d;
    end
  end

  assign hit = hit_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_below_event: assert property (
    enable && watched && !direction && val < threshold |=> hit)
    else $error("below threshold store gave no event");
  a_idle_quiet: assert property (
    !(enable && watched) |=> !hit)
    else $error("event without watched store");
endmodule : arc_watch
`default_nettype wire

// ==== arc_seq_model.sv ====
// Stand-in for the conversion sequencer that feeds the result bank.
// Assumes the bench calls its tasks; each store strobe lasts one cycle.
`timescale 1ns/1ps
`default_nettype none
module arc_seq_model (
  input  wire logic  clk_sys,      // System clock
  output logic       conv_store,   // Normal store strobe
  output logic [3:0] conv_index,   // Normal slot index
  output logic [9:0] conv_result,  // Normal result value
  output logic       prio_store,   // Priority store strobe
  output logic [9:0] prio_result   // Priority result value
);
  // Idle from time zero
  initial begin
    conv_store  = 1'b0;
    conv_index  = 4'h0;
    conv_result = 10'h000;
    prio_store  = 1'b0;
    prio_result = 10'h000;
  end

  // Normal store; idle lines then show the inverse, not a stale copy
  task automatic store_norm(input logic [3:0] idx, input logic [9:0] val);
    @(posedge clk_sys);
    conv_store  <= 1'b1;
    conv_index  <= idx;
    conv_result <= val;
    @(posedge clk_sys);
    conv_store  <= 1'b0;
    conv_index  <= ~idx;
    conv_result <= ~val;
  endtask : store_norm

  // Priority store, same shape as a normal one
  task automatic store_prio(input logic [9:0] val);
    @(posedge clk_sys);
    prio_store  <= 1'b1;
    prio_result <= val;
    @(posedge clk_sys);
    prio_store  <= 1'b0;
    prio_result <= ~val;
  endtask : store_prio
endmodule : arc_seq_model
`default_nettype wire

// ==== arc_regs_tb.sv ====
// Self-checking bench for the result and threshold register bank.
// Assumes the sequencer model beside it and whole-word register accesses.
`timescale 1ns/1ps
`default_nettype none
module arc_regs_tb;
  logic        clk_sys     = 1'b0;           // 125 MHz clock
  logic        rst_b       = 1'b0;           // Reset, active low
  logic [7:0]  reg_addr    = 8'h00;          // Register address
  logic [31:0] reg_wdata   = 32'h0000_0000;  // Write data
  logic        reg_wr      = 1'b0;           // Write strobe
  logic        reg_rd      = 1'b0;           // Read strobe
  logic [31:0] reg_rdata;                    // Read data
  logic        conv_store;                   // Sequencer lines
  logic [3:0]  conv_index;
  logic [9:0]  conv_result;
  logic        prio_store;
  logic [9:0]  prio_result;
  logic        irq;                          // Level interrupt
  int          n_mismatch  = 0;              // Mismatches seen
  int          n_tests     = 0;              // Comparisons made

  // Clock, 8 ns period
  always #4 clk_sys = ~clk_sys;

  arc_regs arc_regs_i (
    .clk_sys     (clk_sys),
    .rst_b       (rst_b),
    .reg_addr    (reg_addr),
    .reg_wdata   (reg_wdata),
    .reg_wr      (reg_wr),
    .reg_rd      (reg_rd),
    .reg_rdata   (reg_rdata),
    .conv_store  (conv_store),
    .conv_index  (conv_index),
    .conv_result (conv_result),
    .prio_store  (prio_store),
    .prio_result (prio_result),
    .irq         (irq)
  );

  arc_seq_model arc_seq_model_i (
    .clk_sys     (clk_sys),
    .conv_store  (conv_store),
    .conv_index  (conv_index),
    .conv_result (conv_result),
    .prio_store  (prio_store),
    .prio_result (prio_result)
  );

  // Expected result word: value, overwrite and stored flags
  function automatic logic [31:0] res_word(input logic [9:0] v,
                                           input logic o, input logic s);
    return {16'h0000, v, 4'h0, o, s};
  endfunction : res_word

  // Expected threshold word
  function automatic logic [31:0] thr_word(input logic [9:0] v);
    return {16'h0000, v, 6'h00};
  endfunction : thr_word

  // Verdict and end of run
  task automatic close_out;
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask : chk

  // One-cycle whole-word write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask : wr

  // One-cycle read, data checked in the following cycle only
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask : chk_rd

  // Interrupt level, after the last edge settled
  task automatic chk_irq(input logic e);
    #1;
    chk({31'h0, irq}, {31'h0, e});
  endtask : chk_irq

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    close_out();
  end

  // Test sequence
  initial begin
    logic [9:0] v;
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    // Reset values, unmapped places read zero
    for (int a = 0; a <= 8'h4c; a += 4) chk_rd(8'(a), 32'h0);
    wr(8'h34, 32'hffff_ffff);
    chk_rd(8'h34, 32'h0000_ffc0);
    wr(8'h38, 32'h5555_aaaa);
    chk_rd(8'h38, 32'h0000_aa80);
    wr(8'hfc, 32'hffff_ffff);
    chk_rd(8'hfc, 32'h0);
    // Every normal slot: store, read, read again
    for (int n = 0; n < 12; n++) begin
      v = 10'(n * 83 + 7);
      arc_seq_model_i.store_norm(4'(n), v);
      chk_rd(8'(4 * n), res_word(v, 1'b0, 1'b1));
      chk_rd(8'(4 * n), res_word(v, 1'b0, 1'b0));
    end
    // Out-of-range index leaves the bank alone
    arc_seq_model_i.store_norm(4'hc, 10'h3ff);
    chk_rd(8'h00, res_word(10'h007, 1'b0, 1'b0));
    chk_rd(8'h44, 32'h0);
    // Overwrite of an unread slot, masked then unmasked interrupt
    arc_seq_model_i.store_norm(4'hb, 10'h2aa);
    arc_seq_model_i.store_norm(4'hb, 10'h155);
    chk_rd(8'h44, 32'h4);
    chk_irq(1'b0);
    wr(8'h48, 32'hf);
    chk_irq(1'b1);
    chk_rd(8'h2c, res_word(10'h155, 1'b1, 1'b1));
    chk_rd(8'h2c, res_word(10'h155, 1'b0, 1'b0));
    wr(8'h44, 32'h4);
    chk_irq(1'b0);
    // Store and read of one slot in the same cycle
    arc_seq_model_i.store_norm(4'h2, 10'h111);
    fork
      chk_rd(8'h08, res_word(10'h111, 1'b0, 1'b1));
      arc_seq_model_i.store_norm(4'h2, 10'h222);
    join
    chk_rd(8'h08, res_word(10'h222, 1'b0, 1'b1));
    // Normal and priority stores together
    fork
      arc_seq_model_i.store_norm(4'h5, 10'h055);
      arc_seq_model_i.store_prio(10'h0aa);
    join
    chk_rd(8'h14, res_word(10'h055, 1'b0, 1'b1));
    chk_rd(8'h30, res_word(10'h0aa, 1'b0, 1'b1));
    chk_rd(8'h30, res_word(10'h0aa, 1'b0, 1'b0));
    // Priority overwrite
    arc_seq_model_i.store_prio(10'h1ff);
    arc_seq_model_i.store_prio(10'h3c0);
    chk_rd(8'h44, 32'h8);
    chk_rd(8'h30, res_word(10'h3c0, 1'b1, 1'b1));
    chk_rd(8'h30, res_word(10'h3c0, 1'b0, 1'b0));
    wr(8'h44, 32'hf);
    // Watch 0 below threshold on each normal code
    wr(8'h34, thr_word(10'h100));
    for (int s = 0; s < 8; s++) begin
      wr(8'h3c, {26'h0, 1'b0, 4'(s), 1'b1});
      arc_seq_model_i.store_norm(4'(s), 10'h0ff);
      chk_rd(8'h44, 32'h1);
      chk_irq(1'b1);
      wr(8'h44, 32'h1);
      chk_rd(8'(4 * s), res_word(10'h0ff, 1'b0, 1'b1));
    end
    // Equal gives nothing, unselected slot gives nothing
    arc_seq_model_i.store_norm(4'h7, 10'h100);
    chk_rd(8'h44, 32'h0);
    chk_rd(8'h1c, res_word(10'h100, 1'b0, 1'b1));
    arc_seq_model_i.store_norm(4'h6, 10'h000);
    chk_rd(8'h44, 32'h0);
    // Watch 0 above threshold
    wr(8'h3c, 32'h2f);
    arc_seq_model_i.store_norm(4'h7, 10'h101);
    chk_rd(8'h44, 32'h1);
    wr(8'h44, 32'h1);
    // Watch 1 on the priority slot, above
    wr(8'h38, thr_word(10'h200));
    wr(8'h40, 32'h35);
    arc_seq_model_i.store_prio(10'h201);
    chk_rd(8'h44, 32'h2);
    chk_irq(1'b1);
    chk_rd(8'h30, res_word(10'h201, 1'b0, 1'b1));
    wr(8'h44, 32'h2);
    chk_irq(1'b0);
    arc_seq_model_i.store_prio(10'h1ff);
    chk_rd(8'h44, 32'h0);
    chk_rd(8'h38, thr_word(10'h200));
    close_out();
  end
endmodule : arc_regs_tb
`default_nettype wire
